// ==== hw/cff_charger_flags.sv ====
// charger fault status and latched event flag register bank
//
// Behaviour
// - fault bit 7 shows input overvoltage protection
// - fault bit 6 shows thermal shutdown
// - fault bit 5 shows battery overvoltage
// - fault bit 4 shows safety timer expired
// - reserved bits always read zero
// - flag1 bit 7 conversion done, zero continuous
// - flag1 bit 6 input current regulation rise
// - flag1 bit 5 input voltage regulation rise
// - flag1 bit 4 die thermal regulation rise
// - flag1 bit 3 watchdog expired rise
// - flag1 bit 0 charge state change
// - flag2 bit 7 power good toggle
// - flag2 bit 4 input source change
// - flag2 bit 2 thermistor zone change
// - flag2 bit 1 current optimizer change
// - flag2 bit 0 minimum system regulation change
// - flag1 resets zero, register reset clears
// - flag2 resets zero, register reset clears
// - fault bits live, untouched by resets
// - unmasked flag events pulse the interrupt
`timescale 1ns/1ps
`default_nettype none
module cff_charger_flags (
	input wire logic ref_clk, // 20 MHz device clock
	input wire logic reset, // asynchronous, active high
	input wire logic reg_reset_cmd, // register reset command pulse
	input wire logic watchdog_expired_status, // watchdog expired level
	input wire logic input_overvoltage_status, // in input overvoltage protection
	input wire logic thermal_shutdown_status, // in thermal shutdown
	input wire logic battery_overvoltage_status, // battery above threshold
	input wire logic safety_timer_expired_status, // safety timer expired
	input wire logic conversion_done, // one-shot conversion complete pulse
	input wire logic continuous_mode, // converter in continuous mode
	input wire logic input_current_regulation_active, // input current regulation
	input wire logic input_voltage_regulation_active, // input voltage regulation
	input wire logic die_thermal_regulation_active, // die thermal regulation
	input wire logic [cff_pkg::CFF_CHARGE_W-1:0] charge_state_field, // charge state
	input wire logic power_good_signal, // power good
	input wire logic [cff_pkg::CFF_SOURCE_W-1:0] input_source_field, // source detection
	input wire logic [cff_pkg::CFF_ZONE_W-1:0] thermistor_zone_field, // thermistor zone
	input wire logic [cff_pkg::CFF_OPT_W-1:0] current_optimizer_field, // optimizer state
	input wire logic minimum_system_voltage, // in minimum system regulation
	input wire logic [cff_pkg::CFF_DATA_W-1:0] mask_first, // masks for flag register 1
	input wire logic [cff_pkg::CFF_DATA_W-1:0] mask_second, // masks for flag register 2
	input wire logic bus_en, // register access strobe
	input wire logic bus_write, // access is a write
	input wire logic [cff_pkg::CFF_ADDR_W-1:0] bus_addr, // register address
	output logic [cff_pkg::CFF_DATA_W-1:0] bus_rdata, // read data
	output logic bus_rvalid, // read data valid pulse
	output logic int_pulse // one-cycle interrupt pulse
);
	import cff_pkg::*;

	logic primed;
	logic watchdog_prev;
	logic icur_prev;
	logic ivolt_prev;
	logic dtherm_prev;
	logic [CFF_CHARGE_W-1:0] charge_prev;
	logic pgood_prev;
	logic [CFF_SOURCE_W-1:0] source_prev;
	logic [CFF_ZONE_W-1:0] zone_prev;
	logic [CFF_OPT_W-1:0] opt_prev;
	logic minsys_prev;
	logic [CFF_DATA_W-1:0] flags_first;
	logic [CFF_DATA_W-1:0] flags_second;
	logic [CFF_DATA_W-1:0] event_first;
	logic [CFF_DATA_W-1:0] event_second;
	logic [CFF_DATA_W-1:0] fault_live;
	logic [CFF_DATA_W-1:0] next_flags_first;
	logic [CFF_DATA_W-1:0] next_flags_second;
	logic [CFF_DATA_W-1:0] next_rdata;
	logic read_access;
	logic clear_first;
	logic clear_second;
	cff_sel_t sel;

	// address decode, shared by read mux and read-clear
	function automatic cff_sel_t cff_decode(input logic [CFF_ADDR_W-1:0] addr);
		cff_sel_t s;
		s = CFF_SEL_NONE;
		if (addr == CFF_ADDR_FAULT) begin
			s = CFF_SEL_FAULT;
		end else if (addr == CFF_ADDR_FLAGS1) begin
			s = CFF_SEL_FLAGS1;
		end else if (addr == CFF_ADDR_FLAGS2) begin
			s = CFF_SEL_FLAGS2;
		end
		return s;
	endfunction

	// only reads act; writes fall through untouched
	assign read_access = bus_en && !bus_write;
	assign sel = cff_decode(bus_addr);
	assign clear_first = read_access && (sel == CFF_SEL_FLAGS1);
	assign clear_second = read_access && (sel == CFF_SEL_FLAGS2);

	// edge detection waits one cycle after reset so stale history raises nothing
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			primed <= 1'b0;
		end else begin
			primed <= 1'b1;
		end
	end

	// history of monitored signals
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			watchdog_prev <= 1'b0;
			icur_prev <= 1'b0;
			ivolt_prev <= 1'b0;
			dtherm_prev <= 1'b0;
			charge_prev <= '0;
			pgood_prev <= 1'b0;
			source_prev <= '0;
			zone_prev <= '0;
			opt_prev <= '0;
			minsys_prev <= 1'b0;
		end else begin
			watchdog_prev <= watchdog_expired_status;
			icur_prev <= input_current_regulation_active;
			ivolt_prev <= input_voltage_regulation_active;
			dtherm_prev <= die_thermal_regulation_active;
			charge_prev <= charge_state_field;
			pgood_prev <= power_good_signal;
			source_prev <= input_source_field;
			zone_prev <= thermistor_zone_field;
			opt_prev <= current_optimizer_field;
			minsys_prev <= minimum_system_voltage;
		end
	end

	// events of the first flag register
	always_comb begin
		event_first = CFF_ZERO_BYTE;
		event_first[CFF_F1_CONV_DONE] = conversion_done && !continuous_mode;
		if (primed) begin
			event_first[CFF_F1_INPUT_CURRENT] = input_current_regulation_active && !icur_prev;
			event_first[CFF_F1_INPUT_VOLTAGE] = input_voltage_regulation_active && !ivolt_prev;
			event_first[CFF_F1_DIE_THERMAL] = die_thermal_regulation_active && !dtherm_prev;
			event_first[CFF_F1_WATCHDOG] = watchdog_expired_status && !watchdog_prev;
			event_first[CFF_F1_CHARGE_STATE] = charge_state_field != charge_prev;
		end
	end

	// events of the second flag register
	always_comb begin
		event_second = CFF_ZERO_BYTE;
		if (primed) begin
			event_second[CFF_F2_POWER_GOOD] = power_good_signal != pgood_prev;
			event_second[CFF_F2_INPUT_SOURCE] = input_source_field != source_prev;
			event_second[CFF_F2_THERMISTOR] = thermistor_zone_field != zone_prev;
			event_second[CFF_F2_OPTIMIZER] = current_optimizer_field != opt_prev;
			event_second[CFF_F2_MIN_SYSTEM] = minimum_system_voltage != minsys_prev;
		end
	end

	// next flag values: a new event beats a read-clear or a register reset
	always_comb begin
		next_flags_first = flags_first;
		next_flags_second = flags_second;
		if (reg_reset_cmd || clear_first) begin
			next_flags_first = CFF_FLAGS_RESET;
		end
		if (reg_reset_cmd || clear_second) begin
			next_flags_second = CFF_FLAGS_RESET;
		end
		next_flags_first = (next_flags_first | event_first) & CFF_FLAGS1_USED;
		next_flags_second = (next_flags_second | event_second) & CFF_FLAGS2_USED;
		if (continuous_mode) begin
			next_flags_first[CFF_F1_CONV_DONE] = 1'b0;
		end
	end

	// first flag register; watchdog expiry clears like every other bit on read or register reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flags_first <= CFF_FLAGS_RESET;
		end else begin
			flags_first <= next_flags_first;
		end
	end

	// second flag register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flags_second <= CFF_FLAGS_RESET;
		end else begin
			flags_second <= next_flags_second;
		end
	end

	// live fault conditions, no storage so no reset can alter them
	always_comb begin
		fault_live = CFF_ZERO_BYTE;
		fault_live[CFF_FLT_INPUT_OV] = input_overvoltage_status;
		fault_live[CFF_FLT_THERMAL_SD] = thermal_shutdown_status;
		fault_live[CFF_FLT_BATTERY_OV] = battery_overvoltage_status;
		fault_live[CFF_FLT_TIMER] = safety_timer_expired_status;
	end

	// read multiplexer; flags read as held before this cycle's clear
	always_comb begin
		next_rdata = CFF_ZERO_BYTE;
		unique case (sel)
			CFF_SEL_NONE: begin
				next_rdata = CFF_ZERO_BYTE;
			end
			CFF_SEL_FAULT: begin
				next_rdata = fault_live & CFF_FAULT_USED;
			end
			CFF_SEL_FLAGS1: begin
				next_rdata = flags_first & CFF_FLAGS1_USED;
			end
			CFF_SEL_FLAGS2: begin
				next_rdata = flags_second & CFF_FLAGS2_USED;
			end
		endcase
	end

	// registered read answer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus_rdata <= CFF_ZERO_BYTE;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= read_access;
			if (read_access) begin
				bus_rdata <= next_rdata;
			end
		end
	end

	// interrupt pulse for any event whose mask bit is zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			int_pulse <= 1'b0;
		end else begin
			int_pulse <= |(event_first & ~mask_first & CFF_FLAGS1_USED) ||
				|(event_second & ~mask_second & CFF_FLAGS2_USED);
		end
	end
endmodule
`default_nettype wire

// ==== hw/cff_pkg.sv ====
// constants for the charger fault status and event flag registers
package cff_pkg;
	// register map
	localparam logic [7:0] CFF_ADDR_FAULT = 8'h0e;
	localparam logic [7:0] CFF_ADDR_FLAGS1 = 8'h0f;
	localparam logic [7:0] CFF_ADDR_FLAGS2 = 8'h10;
	localparam int CFF_ADDR_W = 8;
	localparam int CFF_DATA_W = 8;

	// fault status bit positions
	localparam int CFF_FLT_INPUT_OV = 7;
	localparam int CFF_FLT_THERMAL_SD = 6;
	localparam int CFF_FLT_BATTERY_OV = 5;
	localparam int CFF_FLT_TIMER = 4;

	// first flag register bit positions
	localparam int CFF_F1_CONV_DONE = 7;
	localparam int CFF_F1_INPUT_CURRENT = 6;
	localparam int CFF_F1_INPUT_VOLTAGE = 5;
	localparam int CFF_F1_DIE_THERMAL = 4;
	localparam int CFF_F1_WATCHDOG = 3;
	localparam int CFF_F1_CHARGE_STATE = 0;

	// second flag register bit positions
	localparam int CFF_F2_POWER_GOOD = 7;
	localparam int CFF_F2_INPUT_SOURCE = 4;
	localparam int CFF_F2_THERMISTOR = 2;
	localparam int CFF_F2_OPTIMIZER = 1;
	localparam int CFF_F2_MIN_SYSTEM = 0;

	// implemented bits; everything else reads zero
	localparam logic [7:0] CFF_FAULT_USED = 8'hf0;
	localparam logic [7:0] CFF_FLAGS1_USED = 8'hf9;
	localparam logic [7:0] CFF_FLAGS2_USED = 8'h97;

	// reset and idle values
	localparam logic [7:0] CFF_FLAGS_RESET = 8'h00;
	localparam logic [7:0] CFF_ZERO_BYTE = 8'h00;

	// field widths of the monitored status fields
	localparam int CFF_CHARGE_W = 3;
	localparam int CFF_SOURCE_W = 3;
	localparam int CFF_ZONE_W = 3;
	localparam int CFF_OPT_W = 2;

	// register select decode
	typedef enum logic [1:0] {
		CFF_SEL_NONE = 2'b00,
		CFF_SEL_FAULT = 2'b01,
		CFF_SEL_FLAGS1 = 2'b10,
		CFF_SEL_FLAGS2 = 2'b11
	} cff_sel_t;
endpackage

// ==== tb/cff_flags_chk.sv ====
// port assertions for the charger flag bank
`timescale 1ns/1ps
`default_nettype none
module cff_flags_chk (
	input wire logic ref_clk, // clock
	input wire logic reset, // async reset
	input wire logic input_overvoltage_status, // fault
	input wire logic thermal_shutdown_status, // fault
	input wire logic battery_overvoltage_status, // fault
	input wire logic safety_timer_expired_status, // fault
	input wire logic input_current_regulation_active, // level
	input wire logic power_good_signal, // level
	input wire logic minimum_system_voltage, // level
	input wire logic [7:0] mask_first, // masks 1
	input wire logic [7:0] mask_second, // masks 2
	input wire logic bus_en, // strobe
	input wire logic bus_write, // write
	input wire logic [7:0] bus_addr, // address
	input wire logic [7:0] bus_rdata, // read data
	input wire logic bus_rvalid, // read valid
	input wire logic int_pulse // interrupt
);
	logic live;
	logic rd;
	// read strobe
	assign rd = bus_en && !bus_write;
	// change detection armed one edge after reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) live <= 1'b0;
		else live <= 1'b1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	read_answer_a: assert property (rd |=> bus_rvalid) else $error("read not answered");
	write_ignored_a: assert property (bus_en && bus_write |=> !bus_rvalid) else $error("write answered");
	fault_live_a: assert property (rd && bus_addr == 8'h0e |=> bus_rdata == {$past(input_overvoltage_status),
		$past(thermal_shutdown_status), $past(battery_overvoltage_status), $past(safety_timer_expired_status), 4'h0})
		else $error("fault byte wrong");
	flag1_reserved_a: assert property (rd && bus_addr == 8'h0f |=> bus_rdata[2:1] == 2'b00) else $error("flag1 reserved");
	flag2_reserved_a: assert property (rd && bus_addr == 8'h10 |=> (bus_rdata & 8'h68) == 8'h00) else $error("flag2 reserved");
	unmapped_zero_a: assert property (rd && !(bus_addr inside {[8'h0e:8'h10]}) |=> bus_rdata == 8'h00) else $error("unmapped");
	pg_toggle_a: assert property (live && $changed(power_good_signal) && !mask_second[7] |=> int_pulse) else $error("pg irq");
	sysmin_change_a: assert property (live && $changed(minimum_system_voltage) && !mask_second[0] |=> int_pulse) else $error("sys irq");
	current_rise_a: assert property (live && $rose(input_current_regulation_active) && !mask_first[6] |=> int_pulse) else $error("cur irq");
endmodule
bind cff_charger_flags cff_flags_chk chk_u (.ref_clk, .reset, .input_overvoltage_status, .thermal_shutdown_status,
	.battery_overvoltage_status, .safety_timer_expired_status, .input_current_regulation_active, .power_good_signal,
	.minimum_system_voltage, .mask_first, .mask_second, .bus_en, .bus_write, .bus_addr, .bus_rdata, .bus_rvalid, .int_pulse);
`default_nettype wire

// ==== tb/cff_host.sv ====
// host model issuing register accesses on the strobe port
`timescale 1ns/1ps
`default_nettype none
module cff_host (
	input wire logic ref_clk, // clock
	output logic bus_en = 1'b0, // strobe
	output logic bus_write = 1'b0, // write
	output logic [7:0] bus_addr = 8'h00 // address
);
	// one strobe cycle, launched and released at falling edges
	task automatic acc(input logic w, input logic [7:0] a);
		bus_write = w;
		bus_addr = a;
		bus_en = 1'b1;
		@(negedge ref_clk);
		bus_en = 1'b0;
		bus_addr = ~a; // released address does not keep its value
	endtask
endmodule
`default_nettype wire

// ==== tb/cff_charger_flags_tb_top.sv ====
// self-checking bench for the charger flag bank
`timescale 1ns/1ps
`default_nettype none
module cff_charger_flags_tb_top;
	logic ref_clk, live, rd;
	logic reset = 1'b1, reg_reset_cmd = 1'b0, conversion_done = 1'b0, continuous_mode = 1'b0, xi = 1'b0, xv = 1'b0;
	logic [16:0] stim = '0, pstim, rse, chg;
	logic [3:0] flt = 4'h0;
	logic [7:0] mask_first = 8'h00, mask_second = 8'h00, m1, m2, e1, e2, xr, bus_addr, bus_rdata;
	logic bus_en, bus_write, bus_rvalid, int_pulse;
	logic [7:0] addr_l [4] = '{8'h0e, 8'h0f, 8'h10, 8'h11};
	int errors = 0;
	int cmp_count = 0;
	cff_charger_flags dut_u (.ref_clk, .reset, .reg_reset_cmd, .watchdog_expired_status(stim[13]),
		.input_overvoltage_status(flt[3]), .thermal_shutdown_status(flt[2]), .battery_overvoltage_status(flt[1]),
		.safety_timer_expired_status(flt[0]), .conversion_done, .continuous_mode,
		.input_current_regulation_active(stim[16]), .input_voltage_regulation_active(stim[15]),
		.die_thermal_regulation_active(stim[14]), .charge_state_field(stim[12:10]), .power_good_signal(stim[9]),
		.input_source_field(stim[8:6]), .thermistor_zone_field(stim[5:3]), .current_optimizer_field(stim[2:1]),
		.minimum_system_voltage(stim[0]), .mask_first, .mask_second, .bus_en, .bus_write, .bus_addr, .bus_rdata,
		.bus_rvalid, .int_pulse);
	cff_host host_u (.ref_clk, .bus_en, .bus_write, .bus_addr);
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// reference model of flags, interrupt and read answer
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			{m1, m2, xi, xv, live} = '0;
			pstim = stim;
		end else begin
			rse = stim & ~pstim & {17{live}};
			chg = (stim ^ pstim) & {17{live}};
			e1 = {conversion_done & ~continuous_mode, rse[16:13], 2'b00, |chg[12:10]};
			e2 = {chg[9], 2'b00, |chg[8:6], 1'b0, |chg[5:3], |chg[2:1], chg[0]};
			xi = |(e1 & ~mask_first) || |(e2 & ~mask_second);
			rd = bus_en & ~bus_write;
			xv = rd;
			if (continuous_mode) m1[7] = 1'b0;
			xr = bus_addr == 8'h0e ? {flt, 4'h0} : bus_addr == 8'h0f ? m1 : bus_addr == 8'h10 ? m2 : 8'h00;
			if (reg_reset_cmd || rd && bus_addr == 8'h0f) m1 = 8'h00;
			if (reg_reset_cmd || rd && bus_addr == 8'h10) m2 = 8'h00;
			m1 = m1 | e1;
			m2 = m2 | e2;
			if (continuous_mode) m1[7] = 1'b0;
			live = 1'b1;
			pstim = stim;
		end
	end
	// outputs compared at every falling edge
	always @(negedge ref_clk) begin
		if (!reset) begin
			chk({7'h00, int_pulse}, {7'h00, xi});
			chk({7'h00, bus_rvalid}, {7'h00, xv});
			if (xv) chk(bus_rdata, xr);
		end
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		close_out();
	end
	// main sequence
	initial begin
		void'($urandom(72));
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		foreach (addr_l[i]) host_u.acc(1'b1, addr_l[i]);
		foreach (addr_l[i]) host_u.acc(1'b0, addr_l[i]);
		$display("test reset_values done");
		repeat (400) begin
			@(negedge ref_clk);
			stim = stim ^ (17'h1 << ($urandom % 20));
			flt = 4'($urandom);
			mask_first = 8'($urandom);
			mask_second = 8'($urandom);
			conversion_done = ($urandom % 6) == 0;
			reg_reset_cmd = ($urandom % 16) == 0;
			if ($urandom % 16 == 0) continuous_mode = ~continuous_mode;
			if ($urandom % 2) host_u.acc($urandom % 8 == 0, addr_l[$urandom % 4]);
		end
		$display("test random_events done");
		@(negedge ref_clk);
		reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		stim = ~stim;
		@(negedge ref_clk);
		foreach (addr_l[i]) host_u.acc(1'b0, addr_l[i]);
		$display("test second_reset done");
		close_out();
	end
endmodule
`default_nettype wire
